// ### dv/ccf_card_model.sv
// Purpose: card in the field answering with one demodulated strobe per bit period
// Assumes: symbols 1, 0 and C (collision) given as a string, LSB first
// Notes: amplitudes wander between strobes
`timescale 1ns/100ps
module ccf_card_model
  import ccf_pkg::*;
(
  // clock and receiver state
  input wire logic clk,
  input wire logic rx_enable,
  // demodulator strobes
  output logic demod_bit_valid,
  output logic [3:0] demod_amp_first,
  output logic [3:0] demod_amp_second,
  output logic demod_end_pattern
);
  logic [3:0] amp_a_q = 4'h0;
  logic [3:0] amp_b_q = 4'h0;
  logic [3:0] noise_q = 4'h0;

  initial begin
    demod_bit_valid = 1'b0;
    demod_end_pattern = 1'b0;
  end
  // free pattern between strobes
  always @(posedge clk) begin
    noise_q <= noise_q + 4'h5;
  end
  assign demod_amp_first = demod_bit_valid ? amp_a_q : noise_q;
  assign demod_amp_second = demod_bit_valid ? amp_b_q : ~noise_q;

  // answer once the receiver is armed; a collision modulates both halves strongly
  task automatic play(input string sym);
    int i;
    int k;
    for (k = 0; k < 30000 && rx_enable !== 1'b1; k++) @(posedge clk);
    for (i = 0; i <= sym.len(); i++) begin
      repeat (BIT_CYCLES - 1) @(posedge clk);
      if (i == sym.len()) begin
        demod_end_pattern <= 1'b1;
      end else begin
        demod_bit_valid <= 1'b1;
        amp_a_q <= (sym[i] == "0") ? 4'h0 : 4'hC;
        amp_b_q <= (sym[i] == "1") ? 4'h0 : 4'hC;
      end
      @(posedge clk);
      demod_bit_valid <= 1'b0;
      demod_end_pattern <= 1'b0;
    end
  endtask : play
endmodule : ccf_card_model

// ### dv/ccf_framer_props.sv
// Purpose: port-level checks of the receive collision framer
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every framer instance below the module
`timescale 1ns/100ps
module ccf_framer_props
  import ccf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // transmit side
  input wire logic tx_fifo_empty,
  input wire logic tx_fifo_pop,
  input wire logic tx_active,
  // receive side
  input wire logic rx_prepare,
  input wire logic rx_enable,
  input wire logic rx_fifo_write,
  input wire logic receive_done_request
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // a stuck waitrequest hangs software
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer not one cycle");
  unmapped_zero_a: assert property (avs_read && avs_waitrequest && avs_address[3]
    |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
  // end of reception
  done_single_a: assert property (
    receive_done_request |=> !receive_done_request) else $error("end notice too long");
  done_idle_a: assert property (
    receive_done_request |-> !rx_enable && !tx_active) else $error("end notice not idle");
  // sequencing of the combined command
  prep_window_a: assert property (
    rx_prepare |-> !rx_enable && !tx_active) else $error("prepare overlaps link use");
  tx_rx_apart_a: assert property (
    tx_active |-> !rx_enable) else $error("receiver armed while sending");
  pop_nonempty_a: assert property (
    tx_fifo_pop |-> !$past(tx_fifo_empty)) else $error("pop from empty fifo");
  rx_write_quiet_a: assert property (
    rx_fifo_write |-> !tx_active) else $error("fifo write while sending");
  rx_write_pulse_a: assert property (
    rx_fifo_write |=> !rx_fifo_write) else $error("fifo write longer than one cycle");

  // main scenarios
  byte_seen_c: cover property (rx_fifo_write);
  done_seen_c: cover property (receive_done_request);
  prep_done_c: cover property ($fell(rx_prepare));
endmodule : ccf_framer_props

bind ccf_framer ccf_framer_props u_ccf_framer_props (.clk(clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .tx_fifo_empty(tx_fifo_empty), .tx_fifo_pop(tx_fifo_pop), .tx_active(tx_active),
  .rx_prepare(rx_prepare), .rx_enable(rx_enable), .rx_fifo_write(rx_fifo_write),
  .receive_done_request(receive_done_request));

// ### dv/tb_contactless_rx_collision_framer.sv
// Purpose: register-driven transceive runs against a card model
// Assumes: one tx byte per run; status read back over the register bus, received bytes taken from the fifo write port
// Notes: bus answers are taken at the rising edge that shows them
`timescale 1ns/100ps
module tb_contactless_rx_collision_framer
  import ccf_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0, avs_write = 1'b0, tx_fifo_empty = 1'b1;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [7:0] tx_fifo_data = 8'h26;
  logic avs_waitrequest, tx_fifo_pop, tx_bit, tx_active, rx_prepare, rx_enable;
  logic rx_fifo_write, receive_done_request, demod_bit_valid, demod_end_pattern;
  logic [3:0] demod_amp_first, demod_amp_second;
  logic [7:0] rx_fifo_data;
  logic [7:0] rxq[$];
  int n_fail = 0, check_count = 0;

  always #10 clk = ~clk;

  ccf_framer u_ccf_framer (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_fifo_empty(tx_fifo_empty), .tx_fifo_data(tx_fifo_data), .tx_fifo_pop(tx_fifo_pop),
    .tx_bit(tx_bit), .tx_active(tx_active), .demod_bit_valid(demod_bit_valid),
    .demod_amp_first(demod_amp_first), .demod_amp_second(demod_amp_second),
    .demod_end_pattern(demod_end_pattern), .rx_prepare(rx_prepare), .rx_enable(rx_enable),
    .rx_fifo_write(rx_fifo_write), .rx_fifo_data(rx_fifo_data),
    .receive_done_request(receive_done_request));
  ccf_card_model u_ccf_card_model (.clk(clk), .rx_enable(rx_enable),
    .demod_bit_valid(demod_bit_valid), .demod_amp_first(demod_amp_first),
    .demod_amp_second(demod_amp_second), .demod_end_pattern(demod_end_pattern));

  // collect received bytes; the single tx byte is gone once popped
  always @(posedge clk) begin
    if (rx_fifo_write === 1'b1)
      rxq.push_back(rx_fifo_data);
    if (tx_fifo_pop === 1'b1)
      tx_fifo_empty <= 1'b1;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk

  // one bus access; an edge passes between release and the next request
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    for (i = 0; i < 64; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 64) begin
      chk(32'h0, 32'h1, "bus timeout");
      end_of_test();
    end
  endtask : bus

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask : rd_chk

  // start the combined command, let the card answer, wait for the end notice
  task automatic xfer(input string sym);
    int i;
    rxq.delete();
    tx_fifo_empty <= 1'b0;
    bus(1'b1, REG_COMMAND, 32'(CMD_TRANSCEIVE));
    rd_chk(REG_COMMAND, 32'(CMD_TRANSCEIVE), "command busy");
    rd_chk(REG_MAIN_STATUS, 32'(LS_TX_SOF), "state start");
    u_ccf_card_model.play(sym);
    for (i = 0; i < 4000; i++) begin
      @(negedge clk);
      if (receive_done_request === 1'b1)
        break;
    end
    if (i == 4000) begin
      chk(32'h0, 32'h1, "no end notice");
      end_of_test();
    end
    rd_chk(REG_MAIN_STATUS, 32'h8, "state after end");
  endtask : xfer

  task automatic frame_chk(input int n, input logic [7:0] b0, input logic [7:0] b1,
    input logic [31:0] err, input logic [31:0] pos, input logic [31:0] pb);
    chk(32'(rxq.size()), 32'(n), "byte count");
    if (n > 0)
      chk(32'(rxq[0]), 32'(b0), "first byte");
    if (n > 1)
      chk(32'(rxq[1]), 32'(b1), "second byte");
    rd_chk(REG_ERROR, err, "error flags");
    rd_chk(REG_COLL_POS, pos, "collision position");
    rd_chk(REG_PARTIAL_BYTE, pb, "partial byte");
  endtask : frame_chk

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_chk(REG_THRESHOLD, 32'({MIN_LEVEL_RST, COLL_LEVEL_RST}), "threshold reset");
    rd_chk(REG_CONTROL, 32'(CONTROL_RST), "control reset");
    rd_chk(REG_TIMING, 32'({PHASE_RST, RX_DELAY_RST}), "timing reset");
    rd_chk(REG_ERROR, 32'h0, "error reset");
    bus(1'b1, 4'hF, 32'hFFFF_FFFF);
    rd_chk(4'hF, 32'h0, "unmapped");
    // shortest legal delay keeps the run brief
    bus(1'b1, REG_TIMING, 32'h0000_0103);
    rd_chk(REG_TIMING, 32'h103, "timing");
    // data bit 2 collides; odd parity is right for the decoded byte
    xfer("101C110100");
    frame_chk(1, 8'h5E, 8'h00, 32'h8, 32'h3, 32'h0);
    // offset 3, wrong first parity, collision then zero fill, 3-bit tail
    bus(1'b1, REG_PARTIAL_BYTE, 32'h30);
    bus(1'b1, REG_CONTROL, 32'h0B);
    xfer("1101101C11");
    frame_chk(2, 8'h68, 8'h01, 32'h8, 32'h6, 32'h3);
    // collision in the start pattern
    bus(1'b1, REG_CONTROL, 32'h03);
    xfer("C0110");
    chk(32'(rxq.size()), 32'h0, "no data after bad start");
    bus(1'b0, REG_ERROR, 32'h0);
    chk(rd & 32'h1, 32'h1, "frame error");
    // even parity, checksum on, parity bit collides, frame too short for checksum
    bus(1'b1, REG_CONTROL, 32'h05);
    xfer("100000000C");
    frame_chk(1, 8'h00, 8'h00, 32'hE, 32'h0, 32'h0);
    end_of_test();
  end

  // hang guard well above the run length, at about twice it
  initial begin
    repeat (95000) @(posedge clk);
    chk(32'h0, 32'h1, "run timeout");
    end_of_test();
  end
endmodule : tb_contactless_rx_collision_framer

// ### include/ccf_pkg.sv
// Purpose: shared constants for the contactless receive collision framer
// Assumes: 50 MHz clock, Avalon-MM word addressing, 32-bit data
// Notes: register indices are word addresses on the bus
package ccf_pkg;

  // clock and bit timing
  localparam int CLK_HZ = 50_000_000;
  localparam int BIT_RATE_HZ = 105_938; // 13.56 MHz carrier divided by 128
  localparam int BIT_CYCLES = CLK_HZ / BIT_RATE_HZ;
  localparam logic [9:0] BIT_DIV_LAST = 10'(BIT_CYCLES - 1);
  localparam logic [7:0] RX_PREP_COUNTS = 8'h03; // last counts that warm up the receiver

  // command codes
  localparam logic [7:0] CMD_IDLE = 8'h00;
  localparam logic [7:0] CMD_TRANSCEIVE = 8'h1E;

  // register word addresses
  localparam logic [3:0] REG_COMMAND = 4'h0;
  localparam logic [3:0] REG_MAIN_STATUS = 4'h1;
  localparam logic [3:0] REG_ERROR = 4'h2;
  localparam logic [3:0] REG_COLL_POS = 4'h3;
  localparam logic [3:0] REG_PARTIAL_BYTE = 4'h4;
  localparam logic [3:0] REG_THRESHOLD = 4'h5;
  localparam logic [3:0] REG_CONTROL = 4'h6;
  localparam logic [3:0] REG_TIMING = 4'h7;

  // field positions
  localparam int ERR_FRAME_BIT = 0;
  localparam int ERR_PARITY_BIT = 1;
  localparam int ERR_CRC_BIT = 2;
  localparam int ERR_COLL_BIT = 3;
  localparam int CTL_PARITY_EN_BIT = 0;
  localparam int CTL_PARITY_ODD_BIT = 1;
  localparam int CTL_CRC_EN_BIT = 2;
  localparam int CTL_ZERO_FILL_BIT = 3;
  localparam int PB_OFFSET_LSB = 4;
  localparam int TH_MIN_LEVEL_LSB = 4;
  localparam int TM_PHASE_LSB = 8;
  localparam int MS_DONE_BIT = 3;

  // reset values
  localparam logic [3:0] COLL_LEVEL_RST = 4'h4;
  localparam logic [3:0] MIN_LEVEL_RST = 4'h8;
  localparam logic [3:0] CONTROL_RST = 4'h3;
  localparam logic [7:0] RX_DELAY_RST = 8'h06;
  localparam logic [7:0] PHASE_RST = 8'h00;

  // checksum: reflected 16-bit polynomial, preset and good residue
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_PRESET = 16'h6363;
  localparam logic [15:0] CRC_GOOD = 16'h0000;

  // link_state codes seen by software
  localparam logic [2:0] LS_IDLE = 3'h0;
  localparam logic [2:0] LS_TX_SOF = 3'h1;
  localparam logic [2:0] LS_TX_DATA = 3'h2;
  localparam logic [2:0] LS_TX_EOF = 3'h3;
  localparam logic [2:0] LS_GO_RX = 3'h4;
  localparam logic [2:0] LS_WAIT_DELAY = 3'h5;
  localparam logic [2:0] LS_ARMED = 3'h6;

  // sequencer states, gray along the usual path from ST_IDLE to ST_RX_FINISH
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_TX_SOF = 4'h1,
    ST_TX_DATA = 4'h3,
    ST_TX_EOF = 4'h2,
    ST_RX_START = 4'h6,
    ST_RX_DELAY = 4'h7,
    ST_RX_ARMED = 4'h5,
    ST_RX_DATA = 4'h4,
    ST_RX_FINISH = 4'hC
  } ccf_state_type;

endpackage : ccf_pkg

// ### logic/ccf_framer.sv
// Purpose: transceive sequencer and receive framer with bit-collision handling
// Assumes: demodulator strobes arrive on clk; FIFOs are outside this block
// Notes:
// Functional notes
// - both halves modulated means bit collision
// - weaker half above collision_level flags collision
// - collision on parity bit flags parity error
// - keep receiving; collided bit decodes as one
// - zero fill forces later bits to zero
// - first collision position: start 0, LSB 1
// - parity bits never advance the position count
// - start pattern collision: frame error, no data
// - bit offset places first bits mid-byte
// - bit offset clears itself when reception ends
// - report valid bits of final byte
// - with offset, first parity bit unchecked
// - missing start pattern flags frame error
// - bad or too short checksum flags error
// - wrong parity bit flags parity error
// - command 1Eh transmits then receives, software only
// - receive delay and phase shift steer timing
// - link_state codes for idle and transmit phases
// - link_state codes for receive phases
// - delay counts per bit; last three prepare
// - end pattern or weak signal ends reception
//
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/100ps
module ccf_framer
  import ccf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm register slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // transmit fifo read side
  input wire logic tx_fifo_empty,
  input wire logic [7:0] tx_fifo_data,
  output logic tx_fifo_pop,
  // modulator
  output logic tx_bit,
  output logic tx_active,
  // demodulator, one strobe per received bit period
  input wire logic demod_bit_valid,
  input wire logic [3:0] demod_amp_first,
  input wire logic [3:0] demod_amp_second,
  input wire logic demod_end_pattern,
  output logic rx_prepare,
  output logic rx_enable,
  // receive fifo write side
  output logic rx_fifo_write,
  output logic [7:0] rx_fifo_data,
  // end of reception notice
  output logic receive_done_request
);

  // configuration and status registers
  logic [7:0] command_q, receive_delay_q, tx_rx_phase_shift_q, collision_position_q;
  logic [3:0] collision_level_q, min_signal_level_q;
  logic parity_check_enable_q, parity_odd_q, crc_enable_q, zero_fill_after_collision_q;
  logic [2:0] receive_bit_offset_q, receive_valid_last_bits_q;
  logic frame_error_flag_q, parity_error_flag_q, checksum_error_flag_q;
  logic collision_error_flag_q, done_seen_q;

  // sequencer and datapath state
  ccf_state_type state_q;
  logic [9:0] div_q;
  logic tx_tick, rx_tick, tx_have_q, tx_par_q;
  logic [7:0] delay_q, tx_shift_q, rx_shift_q, rx_pos_q;
  logic [3:0] tx_cnt_q, rx_cnt_q;
  logic rx_par_wait_q, rx_sof_q, rx_discard_q, rx_first_q, coll_seen_q;
  logic [15:0] crc_q;
  logic [1:0] byte_cnt_q;

  // bus handshake
  logic bus_req, bus_take, wr_take, start_cmd;
  assign bus_req = avs_read | avs_write;
  assign bus_take = bus_req & ~avs_waitrequest;
  assign wr_take = bus_take & avs_write;
  // only a software write of the code starts the combined command
  assign start_cmd = wr_take && avs_address == REG_COMMAND
    && avs_writedata[7:0] == CMD_TRANSCEIVE && state_q == ST_IDLE;

  // one update of the reflected checksum by a byte
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  // bit decode of the current demodulator strobe
  logic mod_first, mod_second, bit_coll, raw_bit, bit_val, sig_lost;
  logic [3:0] weak_amp;
  always_comb begin
    mod_first = demod_amp_first > min_signal_level_q;
    mod_second = demod_amp_second > min_signal_level_q;
    weak_amp = (demod_amp_first < demod_amp_second) ? demod_amp_first : demod_amp_second;
    bit_coll = mod_first && mod_second && (weak_amp > collision_level_q);
    // a collided bit decodes as one, otherwise the stronger half wins
    raw_bit = bit_coll ? 1'b1 : (demod_amp_first >= demod_amp_second);
    bit_val = (zero_fill_after_collision_q && coll_seen_q) ? 1'b0 : raw_bit;
    sig_lost = !mod_first && !mod_second;
  end

  // receive bit events and the end condition
  logic rx_bit, rx_end, is_parity, par_expect;
  // the first modulated strobe while armed is the start pattern itself
  assign rx_bit = demod_bit_valid && !sig_lost
    && (state_q == ST_RX_ARMED || state_q == ST_RX_DATA);
  assign rx_end = state_q == ST_RX_DATA
    && (demod_end_pattern || (demod_bit_valid && sig_lost));
  assign is_parity = rx_par_wait_q;
  assign par_expect = (^rx_shift_q) ^ parity_odd_q;

  // bus slave: one wait cycle, then the answer stands for one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if (bus_req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      if (avs_read) begin
        unique case (avs_address)
          REG_COMMAND: avs_readdata[7:0] <= command_q;
          REG_MAIN_STATUS: avs_readdata[3:0] <= {done_seen_q, link_code(state_q)};
          REG_ERROR: avs_readdata[3:0] <= {collision_error_flag_q, checksum_error_flag_q,
                                           parity_error_flag_q, frame_error_flag_q};
          REG_COLL_POS: avs_readdata[7:0] <= collision_position_q;
          REG_PARTIAL_BYTE: avs_readdata[7:0] <= {1'b0, receive_bit_offset_q,
                                                  1'b0, receive_valid_last_bits_q};
          REG_THRESHOLD: avs_readdata[7:0] <= {min_signal_level_q, collision_level_q};
          REG_CONTROL: avs_readdata[3:0] <= {zero_fill_after_collision_q, crc_enable_q,
                                             parity_odd_q, parity_check_enable_q};
          REG_TIMING: avs_readdata[15:0] <= {tx_rx_phase_shift_q, receive_delay_q};
          default: avs_readdata <= 32'h0000_0000; // unmapped words read zero
        endcase
      end
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // link_state encoding of the sequencer state
  function automatic logic [2:0] link_code(input ccf_state_type s);
    unique case (s)
      ST_IDLE: return LS_IDLE;
      ST_TX_SOF: return LS_TX_SOF;
      ST_TX_DATA: return LS_TX_DATA;
      ST_TX_EOF: return LS_TX_EOF;
      ST_RX_START, ST_RX_FINISH: return LS_GO_RX;
      ST_RX_DELAY: return LS_WAIT_DELAY;
      ST_RX_ARMED, ST_RX_DATA: return LS_ARMED;
      default: return LS_IDLE;
    endcase
  endfunction : link_code

  // software configuration writes
  always_ff @(posedge clk) begin
    if (rst) begin
      collision_level_q <= COLL_LEVEL_RST;
      min_signal_level_q <= MIN_LEVEL_RST;
      {zero_fill_after_collision_q, crc_enable_q, parity_odd_q, parity_check_enable_q}
        <= CONTROL_RST;
      receive_delay_q <= RX_DELAY_RST;
      tx_rx_phase_shift_q <= PHASE_RST;
    end else if (wr_take) begin
      unique case (avs_address)
        REG_THRESHOLD: {min_signal_level_q, collision_level_q} <= avs_writedata[7:0];
        REG_CONTROL: begin
          parity_check_enable_q <= avs_writedata[CTL_PARITY_EN_BIT];
          parity_odd_q <= avs_writedata[CTL_PARITY_ODD_BIT];
          crc_enable_q <= avs_writedata[CTL_CRC_EN_BIT];
          zero_fill_after_collision_q <= avs_writedata[CTL_ZERO_FILL_BIT];
        end
        REG_TIMING: begin
          receive_delay_q <= avs_writedata[7:0];
          tx_rx_phase_shift_q <= avs_writedata[TM_PHASE_LSB +: 8];
        end
        default: ;
      endcase
    end
  end

  // bit offset: software sets it, end of reception clears it
  always_ff @(posedge clk) begin
    if (rst) begin
      receive_bit_offset_q <= 3'h0;
    end else if (state_q == ST_RX_FINISH) begin
      receive_bit_offset_q <= 3'h0;
    end else if (wr_take && avs_address == REG_PARTIAL_BYTE) begin
      receive_bit_offset_q <= avs_writedata[PB_OFFSET_LSB +: 3];
    end
  end

  // bit clock divider, restarted by a start so the start bit gets a whole period;
  // the receive tick lags by the phase shift
  always_ff @(posedge clk) begin
    if (rst || start_cmd || div_q == BIT_DIV_LAST) begin
      div_q <= 10'h000;
    end else begin
      div_q <= div_q + 10'h001;
    end
  end
  assign tx_tick = div_q == BIT_DIV_LAST;
  assign rx_tick = div_q == {2'b00, tx_rx_phase_shift_q};

  // command register and sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      command_q <= CMD_IDLE;
      delay_q <= 8'h00;
    end else if (wr_take && avs_address == REG_COMMAND && avs_writedata[7:0] == CMD_IDLE) begin
      // software abort returns at once
      state_q <= ST_IDLE;
      command_q <= CMD_IDLE;
    end else begin
      if (start_cmd) begin
        command_q <= CMD_TRANSCEIVE;
      end
      unique case (state_q)
        ST_IDLE: if (start_cmd) state_q <= ST_TX_SOF;
        ST_TX_SOF: if (tx_tick) state_q <= ST_TX_DATA;
        ST_TX_DATA: if (tx_tick && !tx_have_q && tx_fifo_empty) state_q <= ST_TX_EOF;
        ST_TX_EOF: if (tx_tick) state_q <= ST_RX_START;
        ST_RX_START: begin
          state_q <= ST_RX_DELAY;
          delay_q <= receive_delay_q;
        end
        ST_RX_DELAY: begin
          // counts down once per bit, armed on reaching zero
          if (delay_q == 8'h00) begin
            state_q <= ST_RX_ARMED;
          end else if (rx_tick) begin
            delay_q <= delay_q - 8'h01;
          end
        end
        ST_RX_ARMED: if (demod_bit_valid && !sig_lost) state_q <= ST_RX_DATA;
        ST_RX_DATA: if (rx_end) state_q <= ST_RX_FINISH;
        ST_RX_FINISH: begin
          state_q <= ST_IDLE;
          command_q <= CMD_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // transmitter: start bit, bytes with optional parity, end bit
  always_ff @(posedge clk) begin
    if (rst || state_q == ST_IDLE) begin
      tx_bit <= 1'b0;
      tx_fifo_pop <= 1'b0;
      tx_have_q <= 1'b0;
      tx_cnt_q <= 4'h0;
      tx_shift_q <= 8'h00;
      tx_par_q <= 1'b0;
    end else begin
      tx_fifo_pop <= 1'b0;
      if (tx_tick) begin
        unique case (state_q)
          ST_TX_SOF: tx_bit <= 1'b1;
          ST_TX_DATA: begin
            if (tx_have_q && tx_cnt_q < 4'h8) begin
              tx_bit <= tx_shift_q[0];
              tx_shift_q <= tx_shift_q >> 1;
              tx_cnt_q <= tx_cnt_q + 4'h1;
              if (tx_cnt_q == 4'h7 && !parity_check_enable_q) tx_have_q <= 1'b0;
            end else if (tx_have_q) begin
              tx_bit <= tx_par_q;
              tx_have_q <= 1'b0;
            end else if (!tx_fifo_empty) begin
              // next byte goes out from this bit on, bit 0 first
              tx_bit <= tx_fifo_data[0];
              tx_shift_q <= tx_fifo_data >> 1;
              tx_par_q <= (^tx_fifo_data) ^ parity_odd_q;
              tx_cnt_q <= 4'h1;
              tx_have_q <= 1'b1;
              tx_fifo_pop <= 1'b1;
            end
          end
          ST_TX_EOF: tx_bit <= 1'b0;
          default: tx_bit <= 1'b0;
        endcase
      end
    end
  end

  // receive framing, packing, parity, checksum and collision bookkeeping
  always_ff @(posedge clk) begin
    if (rst || state_q == ST_RX_START) begin
      // reset or fresh frame: only the newest frame is reported
      {frame_error_flag_q, parity_error_flag_q, checksum_error_flag_q} <= 3'h0;
      collision_error_flag_q <= 1'b0;
      collision_position_q <= 8'h00;
      receive_valid_last_bits_q <= 3'h0;
      rx_shift_q <= 8'h00;
      rx_cnt_q <= {1'b0, receive_bit_offset_q};
      {rx_par_wait_q, rx_discard_q, coll_seen_q} <= 3'h0;
      rx_sof_q <= 1'b1;
      rx_first_q <= 1'b1;
      rx_pos_q <= 8'h00;
      crc_q <= CRC_PRESET;
      byte_cnt_q <= 2'h0;
      rx_fifo_write <= 1'b0;
      rx_fifo_data <= 8'h00;
    end else begin
      rx_fifo_write <= 1'b0;
      if (rx_bit) begin
        if (bit_coll) begin
          collision_error_flag_q <= 1'b1;
          coll_seen_q <= 1'b1;
          if (!coll_seen_q && !is_parity) begin
            collision_position_q <= rx_pos_q;
          end
        end
        if (rx_sof_q) begin
          rx_sof_q <= 1'b0;
          rx_pos_q <= 8'h01;
          // no clean start pattern: flag it and keep data out of the fifo
          if (bit_coll || !raw_bit) begin
            frame_error_flag_q <= 1'b1;
            rx_discard_q <= 1'b1;
          end
        end else if (is_parity) begin
          rx_par_wait_q <= 1'b0; // position count untouched
          if (!(rx_first_q && receive_bit_offset_q != 3'h0)) begin
            if (bit_coll || bit_val != par_expect) parity_error_flag_q <= 1'b1;
          end
          rx_first_q <= 1'b0;
          rx_cnt_q <= 4'h0;
          rx_shift_q <= 8'h00; // a short last byte must carry no stale bits
          if (!rx_discard_q) begin
            rx_fifo_write <= 1'b1;
            rx_fifo_data <= rx_shift_q;
            crc_q <= crc_byte(crc_q, rx_shift_q);
            if (byte_cnt_q != 2'h3) byte_cnt_q <= byte_cnt_q + 2'h1;
          end
        end else begin
          rx_shift_q[rx_cnt_q[2:0]] <= bit_val;
          rx_pos_q <= rx_pos_q + 8'h01;
          if (rx_cnt_q == 4'h7) begin
            if (parity_check_enable_q) begin
              rx_par_wait_q <= 1'b1;
              rx_cnt_q <= 4'h8;
            end else begin
              // byte complete with no parity slot: forward it now
              rx_cnt_q <= 4'h0;
              rx_first_q <= 1'b0;
              rx_shift_q <= 8'h00;
              if (!rx_discard_q) begin
                rx_fifo_write <= 1'b1;
                rx_fifo_data <= {bit_val, rx_shift_q[6:0]};
                crc_q <= crc_byte(crc_q, {bit_val, rx_shift_q[6:0]});
                if (byte_cnt_q != 2'h3) byte_cnt_q <= byte_cnt_q + 2'h1;
              end
            end
          end else begin
            rx_cnt_q <= rx_cnt_q + 4'h1;
          end
        end
      end else if (rx_end) begin
        // flush a partly filled last byte and report its valid bits
        if (!rx_discard_q && !rx_sof_q && (rx_par_wait_q || rx_cnt_q != 4'h0)) begin
          rx_fifo_write <= 1'b1;
          rx_fifo_data <= rx_shift_q;
        end
        receive_valid_last_bits_q <= rx_par_wait_q ? 3'h0 : rx_cnt_q[2:0];
        if (crc_enable_q && !rx_discard_q) begin
          // short frames cannot hold the checksum at all
          if (byte_cnt_q < 2'h2 || crc_q != CRC_GOOD) checksum_error_flag_q <= 1'b1;
        end
        if (rx_sof_q) frame_error_flag_q <= 1'b1;
      end
    end
  end

  // pin-facing strobes and end-of-reception notice
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_active <= 1'b0;
      rx_prepare <= 1'b0;
      rx_enable <= 1'b0;
      receive_done_request <= 1'b0;
      done_seen_q <= 1'b0;
    end else begin
      tx_active <= state_q == ST_TX_SOF || state_q == ST_TX_DATA || state_q == ST_TX_EOF;
      // analogue front end warms up over the last counts of the delay
      rx_prepare <= state_q == ST_RX_DELAY && delay_q != 8'h00
        && delay_q <= RX_PREP_COUNTS;
      rx_enable <= state_q == ST_RX_ARMED || state_q == ST_RX_DATA;
      receive_done_request <= state_q == ST_RX_FINISH;
      if (state_q == ST_RX_FINISH) begin
        done_seen_q <= 1'b1;
      end else if (start_cmd) begin
        done_seen_q <= 1'b0;
      end
    end
  end

endmodule : ccf_framer
